// *** common/sctx_defs.svh ***
// Offsets, codes and page layout constants for the SCT log transfer block
`ifndef SCTX_DEFS_SVH
`define SCTX_DEFS_SVH
// Task-file codes
`define SCTX_CMD_SMART     8'hb0
`define SCTX_CMD_LOG_RD    8'h2f
`define SCTX_CMD_LOG_WR    8'h3f
`define SCTX_FEAT_RD       8'hd5
`define SCTX_FEAT_WR       8'hd6
`define SCTX_SIG_LO        8'h4f
`define SCTX_SIG_HI        8'hc2
`define SCTX_LOG_STATUS    8'he0
`define SCTX_LOG_DATA      8'he1
`define SCTX_CNT_ONE       8'h01
`define SCTX_CNT_EIGHT     8'h08
// Sector size as a shift
`define SCTX_SECT_SHIFT    9
// Extended status codes
`define SCTX_EXT_OK        16'h0000
`define SCTX_EXT_NO_CMD    16'h000b
`define SCTX_EXT_BG        16'hffff
// Status page bytes
`define SCTX_PG_FMT_VER    16'h0003
`define SCTX_PG_SPEC       16'h0001
`define SCTX_PG_DRV_IDLE   8'h00
`define SCTX_PG_DRV_SCT    8'h05
`define SCTX_PG_TEMP_INV   8'h80
// Host register map, byte addresses
`define SCTX_REG_CTRL      5'h00
`define SCTX_REG_STAT      5'h04
`define SCTX_REG_DATA      5'h08
`define SCTX_REG_IRQ_STS   5'h0c
`define SCTX_REG_IRQ_EN    5'h10
`define SCTX_REG_IRQ_CLR   5'h14
// Control fields
`define SCTX_CTRL_GO       0
`define SCTX_CTRL_OP_LSB   1
`define SCTX_CTRL_LOG      3
`define SCTX_CTRL_CNT_LSB  4
// Operation codes
`define SCTX_OP_STATUS     2'h0
`define SCTX_OP_SCTCMD     2'h1
`define SCTX_OP_XRD        2'h2
`define SCTX_OP_XWR        2'h3
// Interrupt bits
`define SCTX_IRQ_DONE      0
`define SCTX_IRQ_ERR       1
`endif

// *** common/sctx_pkg.sv ***
// Types shared by both ends of the SCT log transfer link
package sctx_pkg;
  typedef struct packed {
    logic [7:0] feature;
    logic [7:0] count_cur;
    logic [7:0] count_prev;
    logic [7:0] lba_low;
    logic [7:0] lba_mid_cur;
    logic [7:0] lba_mid_prev;
    logic [7:0] lba_high;
    logic [7:0] command;
  } sctx_tf_t;

  typedef enum logic [2:0] {
    SCTX_K_BAD,
    SCTX_K_STATUS,
    SCTX_K_SCTCMD,
    SCTX_K_XRD,
    SCTX_K_XWR
  } sctx_kind_t;
endpackage : sctx_pkg

// *** common/sctx_if.sv ***
// Task-file link between host controller and drive
`timescale 1ns/1ps
interface sctx_if;
  import sctx_pkg::*;
  logic           cmd_valid;
  logic           cmd_ready;
  sctx_tf_t       tf;
  logic           h2d_valid;
  logic           h2d_ready;
  logic [7:0]     h2d_data;
  logic           d2h_valid;
  logic           d2h_ready;
  logic [7:0]     d2h_data;
  logic           sts_valid;
  logic           sts_err;

  modport dev (
    input  cmd_valid, tf, h2d_valid, h2d_data, d2h_ready,
    output cmd_ready, h2d_ready, d2h_valid, d2h_data, sts_valid, sts_err
  );
  modport host (
    output cmd_valid, tf, h2d_valid, h2d_data, d2h_ready,
    input  cmd_ready, h2d_ready, d2h_valid, d2h_data, sts_valid, sts_err
  );
endinterface : sctx_if

// *** design/sctx_decode.sv ***
// Classifies a task-file image into an SCT request kind
`timescale 1ns/1ps
`include "sctx_defs.svh"
module sctx_decode (
  input  sctx_pkg::sctx_tf_t   tf_i,
  output sctx_pkg::sctx_kind_t kind_o,
  output logic [7:0]           sectors_o
);
  import sctx_pkg::*;
  logic smart;
  logic log_ok;
  logic log_rd;
  logic log_wr;
  logic f_rd;
  logic f_wr;
  logic one;

  always_comb
  begin
    smart  = tf_i.command == `SCTX_CMD_SMART && tf_i.lba_mid_cur == `SCTX_SIG_LO &&
             tf_i.lba_high == `SCTX_SIG_HI;
    log_ok = tf_i.lba_mid_cur == 8'h00 && tf_i.lba_mid_prev == 8'h00 &&
             tf_i.count_prev == 8'h00;
    log_rd = tf_i.command == `SCTX_CMD_LOG_RD && log_ok;
    log_wr = tf_i.command == `SCTX_CMD_LOG_WR && log_ok;
    f_rd   = smart && tf_i.feature == `SCTX_FEAT_RD;
    f_wr   = smart && tf_i.feature == `SCTX_FEAT_WR;
    one    = tf_i.count_cur == `SCTX_CNT_ONE;
    sectors_o = tf_i.count_cur;
    kind_o = SCTX_K_BAD;
    if (tf_i.lba_low == `SCTX_LOG_STATUS && one)
    begin
      if (f_rd || log_rd)
        kind_o = SCTX_K_STATUS;
      else if (f_wr || log_wr)
        kind_o = SCTX_K_SCTCMD;
    end
    else if (tf_i.lba_low == `SCTX_LOG_DATA)
    begin
      if ((f_rd && tf_i.count_cur != 8'h00) ||
          (log_rd && (one || tf_i.count_cur == `SCTX_CNT_EIGHT)))
        kind_o = SCTX_K_XRD;
      else if ((f_wr && tf_i.count_cur != 8'h00) ||
               (log_wr && (one || tf_i.count_cur == `SCTX_CNT_EIGHT)))
        kind_o = SCTX_K_XWR;
    end
  end
endmodule : sctx_decode

// *** design/sctx_dev.sv ***
// Drive end: serves SCT status page, SCT command key and data transfers
//
// Operation
// - SMART transfer: feature D5h/D6h, command B0h
// - SMART transfer: E1h, signature 4Fh/C2h, count
// - Log transfer: 2Fh/3Fh, E1h, count 01h/08h
// - SMART status: D5h, count 01h, E0h
// - Log status: 2Fh, E0h, count 01h
// - Task status means accepted or error only
// - Reading page E0h returns current status
// - Status request accepted anytime, even busy
// - Status request keeps power and background
// - Host polls status for long commands
// - Transfer without prior command aborts, 000Bh
// - Background execution reports extended status FFFFh
//
// Our own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "sctx_defs.svh"
module sctx_dev (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  sctx_if.dev              link,
  input  wire logic        bg_active_i,
  input  wire logic        bg_done_i,
  input  wire logic [15:0] bg_status_i,
  output logic             sct_cmd_o,
  output logic [15:0]      sct_action_o,
  output logic [15:0]      sct_function_o,
  output logic             usr_wr_valid_o,
  output logic [7:0]       usr_wr_data_o,
  output logic             usr_rd_take_o,
  input  wire logic [7:0]  usr_rd_data_i
);
  import sctx_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE,
    S_TX,
    S_RX,
    S_REPLY
  } sctx_dst_t;

  typedef struct packed {
    sctx_dst_t   st;
    sctx_kind_t  kind;
    logic [16:0] total;
    logic [16:0] idx;
    logic        err;
    logic        issued;
    logic [15:0] ext;
    logic [15:0] act;
    logic [15:0] fn;
    logic        tv;
    logic [7:0]  tdata;
    logic        wv;
    logic [7:0]  wdata;
    logic        take;
    logic        cmd_p;
  } sctx_dstate_t;

  sctx_dstate_t q;
  sctx_dstate_t d;
  sctx_kind_t   kind;
  logic [7:0]   sectors;
  logic [15:0]  ext_rep;
  logic [7:0]   drv;

  //////////////////////////////////////////////////////////////////////////////
  // Status page content
  function automatic logic [7:0] page_byte(input logic [8:0]  a,
                                           input logic [7:0]  ds,
                                           input logic [15:0] es,
                                           input logic [15:0] ac,
                                           input logic [15:0] fc);
    logic [7:0] b;
    b = 8'h00;
    unique case (a)
      9'd0:    b = 8'(`SCTX_PG_FMT_VER & 16'h00ff);
      9'd4:    b = 8'(`SCTX_PG_SPEC & 16'h00ff);
      9'd10:   b = ds;
      9'd14:   b = es[7:0];
      9'd15:   b = es[15:8];
      9'd16:   b = ac[7:0];
      9'd17:   b = ac[15:8];
      9'd18:   b = fc[7:0];
      9'd19:   b = fc[15:8];
      9'd200,
      9'd201,
      9'd202:  b = `SCTX_PG_TEMP_INV;
      default: b = 8'h00;
    endcase
    return b;
  endfunction : page_byte

  sctx_decode sctx_decode_inst (
    .tf_i      (link.tf),
    .kind_o    (kind),
    .sectors_o (sectors)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Link handshakes
  assign link.cmd_ready = q.st == S_IDLE;
  assign link.h2d_ready = q.st == S_RX;
  assign link.d2h_valid = q.tv;
  assign link.d2h_data  = q.tdata;
  assign link.sts_valid = q.st == S_REPLY;
  assign link.sts_err   = q.err;

  assign ext_rep = bg_active_i ? `SCTX_EXT_BG : q.ext;
  assign drv     = bg_active_i ? `SCTX_PG_DRV_SCT : `SCTX_PG_DRV_IDLE;

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    d       = q;
    d.wv    = 1'b0;
    d.take  = 1'b0;
    d.cmd_p = 1'b0;
    if (bg_done_i)
      d.ext = bg_status_i;
    unique case (q.st)
      S_IDLE:
      begin
        if (link.cmd_valid)
        begin
          d.kind  = kind;
          d.idx   = '0;
          d.err   = 1'b0;
          d.total = 17'(sectors) << `SCTX_SECT_SHIFT;
          unique case (kind)
            SCTX_K_BAD:
            begin
              d.err = 1'b1;
              d.st  = S_REPLY;
            end
            SCTX_K_STATUS:
              d.st = S_TX;
            SCTX_K_SCTCMD:
              d.st = S_RX;
            SCTX_K_XRD,
            SCTX_K_XWR:
            begin
              if (!q.issued)
              begin
                d.err = 1'b1;
                d.ext = `SCTX_EXT_NO_CMD;
                d.st  = S_REPLY;
              end
              else
                d.st = (kind == SCTX_K_XRD) ? S_TX : S_RX;
            end
            default:
            begin
              d.err = 1'b1;
              d.st  = S_REPLY;
            end
          endcase
        end
      end
      S_TX:
      begin
        if (!q.tv || link.d2h_ready)
        begin
          if (q.idx == q.total)
          begin
            d.tv = 1'b0;
            d.st = S_REPLY;
            if (q.kind == SCTX_K_XRD)
              d.issued = 1'b0;
          end
          else
          begin
            d.tv  = 1'b1;
            d.idx = q.idx + 17'd1;
            if (q.kind == SCTX_K_STATUS)
              d.tdata = page_byte(q.idx[8:0], drv, ext_rep, q.act, q.fn);
            else
            begin
              d.tdata = usr_rd_data_i;
              d.take  = 1'b1;
            end
          end
        end
      end
      S_RX:
      begin
        if (link.h2d_valid)
        begin
          d.idx = q.idx + 17'd1;
          if (q.kind == SCTX_K_SCTCMD)
          begin
            unique case (q.idx)
              17'd0:   d.act[7:0]  = link.h2d_data;
              17'd1:   d.act[15:8] = link.h2d_data;
              17'd2:   d.fn[7:0]   = link.h2d_data;
              17'd3:   d.fn[15:8]  = link.h2d_data;
              default: d.act       = q.act;
            endcase
          end
          else
          begin
            d.wv    = 1'b1;
            d.wdata = link.h2d_data;
          end
          if (q.idx == q.total - 17'd1)
          begin
            d.st = S_REPLY;
            if (q.kind == SCTX_K_SCTCMD)
            begin
              d.issued = 1'b1;
              d.cmd_p  = 1'b1;
              if (!bg_done_i)
                d.ext = `SCTX_EXT_OK;
            end
            else
              d.issued = 1'b0;
          end
        end
      end
      S_REPLY:
        d.st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      q      <= '0;
      q.st   <= S_IDLE;
      q.kind <= SCTX_K_BAD;
    end
    else
      q <= d;
  end

  //////////////////////////////////////////////////////////////////////////////
  // User side
  assign sct_cmd_o      = q.cmd_p;
  assign sct_action_o   = q.act;
  assign sct_function_o = q.fn;
  assign usr_wr_valid_o = q.wv;
  assign usr_wr_data_o  = q.wdata;
  assign usr_rd_take_o  = q.take;
endmodule : sctx_dev

// *** design/sctx_host.sv ***
// Host controller end: Avalon-MM registers driving the task-file link
`timescale 1ns/1ps
`include "sctx_defs.svh"
module sctx_host (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  sctx_if.host             link,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq_o
);
  import sctx_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE,
    H_ISSUE,
    H_WAIT
  } sctx_hst_t;

  typedef struct packed {
    sctx_hst_t   st;
    sctx_tf_t    tf;
    logic        hv;
    logic [7:0]  hb;
    logic        ack;
    logic [31:0] rdata;
    logic        last_err;
    logic [1:0]  irq;
    logic [1:0]  en;
  } sctx_hstate_t;

  sctx_hstate_t q;
  sctx_hstate_t d;
  logic         rd_data;
  logic         wr_data;

  //////////////////////////////////////////////////////////////////////////////
  // Task-file image for an operation
  function automatic sctx_tf_t mk_tf(input logic [1:0] op,
                                     input logic       use_log,
                                     input logic [7:0] cnt);
    sctx_tf_t t;
    logic     wr;
    logic     xf;
    t  = '0;
    wr = op == `SCTX_OP_SCTCMD || op == `SCTX_OP_XWR;
    xf = op == `SCTX_OP_XRD || op == `SCTX_OP_XWR;
    t.lba_low   = xf ? `SCTX_LOG_DATA : `SCTX_LOG_STATUS;
    t.count_cur = xf ? cnt : `SCTX_CNT_ONE;
    if (use_log)
      t.command = wr ? `SCTX_CMD_LOG_WR : `SCTX_CMD_LOG_RD;
    else
    begin
      t.command     = `SCTX_CMD_SMART;
      t.feature     = wr ? `SCTX_FEAT_WR : `SCTX_FEAT_RD;
      t.lba_mid_cur = `SCTX_SIG_LO;
      t.lba_high    = `SCTX_SIG_HI;
    end
    return t;
  endfunction : mk_tf

  assign rd_data = avs_read && !q.ack && avs_address == `SCTX_REG_DATA;
  assign wr_data = avs_write && avs_address == `SCTX_REG_DATA;

  assign avs_waitrequest = (avs_read && !q.ack) || (wr_data && q.hv);
  assign avs_readdata    = q.rdata;
  assign irq_o           = |(q.irq & q.en);

  assign link.cmd_valid = q.st == H_ISSUE;
  assign link.tf        = q.tf;
  assign link.h2d_valid = q.hv;
  assign link.h2d_data  = q.hb;
  assign link.d2h_ready = rd_data;

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    d     = q;
    d.ack = 1'b0;
    if (q.hv && link.h2d_ready)
      d.hv = 1'b0;
    if (avs_read && !q.ack)
    begin
      d.ack = 1'b1;
      unique case (avs_address)
        `SCTX_REG_STAT:    d.rdata = {30'h0, q.last_err, q.st != H_IDLE};
        `SCTX_REG_DATA:
        begin
          d.ack   = link.d2h_valid;
          d.rdata = {24'h0, link.d2h_data};
        end
        `SCTX_REG_IRQ_STS: d.rdata = {30'h0, q.irq};
        `SCTX_REG_IRQ_EN:  d.rdata = {30'h0, q.en};
        default:           d.rdata = 32'h0;
      endcase
    end
    if (avs_write)
    begin
      unique case (avs_address)
        `SCTX_REG_CTRL:
          if (avs_writedata[`SCTX_CTRL_GO] && q.st == H_IDLE)
          begin
            d.tf = mk_tf(avs_writedata[`SCTX_CTRL_OP_LSB +: 2],
                         avs_writedata[`SCTX_CTRL_LOG],
                         avs_writedata[`SCTX_CTRL_CNT_LSB +: 8]);
            d.st = H_ISSUE;
          end
        `SCTX_REG_DATA:
          if (!q.hv)
          begin
            d.hv = 1'b1;
            d.hb = avs_writedata[7:0];
          end
        `SCTX_REG_IRQ_EN:  d.en  = avs_writedata[1:0];
        `SCTX_REG_IRQ_CLR: d.irq = q.irq & ~avs_writedata[1:0];
        default:           d.en  = d.en;
      endcase
    end
    unique case (q.st)
      H_IDLE:
        d.st = d.st;
      H_ISSUE:
        if (link.cmd_ready)
          d.st = H_WAIT;
      H_WAIT:
        if (link.sts_valid)
        begin
          d.st                  = H_IDLE;
          d.last_err            = link.sts_err;
          d.irq[`SCTX_IRQ_DONE] = 1'b1;
          if (link.sts_err)
            d.irq[`SCTX_IRQ_ERR] = 1'b1;
        end
      default:
        d.st = H_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      q    <= '0;
      q.st <= H_IDLE;
    end
    else
      q <= d;
  end
endmodule : sctx_host

// *** tb/sctx_chk.sv ***
// Assertions on the task-file link between host and drive ends
`timescale 1ns/1ps
module sctx_chk (
  input wire logic               clk_sys_i,
  input wire logic               reset_i,
  input wire logic               cmd_valid,
  input wire logic               cmd_ready,
  input wire sctx_pkg::sctx_tf_t tf,
  input wire logic               h2d_valid,
  input wire logic               h2d_ready,
  input wire logic [7:0]         h2d_data,
  input wire logic               d2h_valid,
  input wire logic               d2h_ready,
  input wire logic [7:0]         d2h_data,
  input wire logic               sts_valid,
  input wire logic               sts_err
);
  import sctx_pkg::*;
  logic take;
  logic st_req;
  logic stat_q;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  assign take   = cmd_valid && cmd_ready;
  assign st_req = take && tf.lba_low == 8'he0 && tf.count_cur == 8'h01
                  && ((tf.command == 8'h2f && tf.count_prev == 8'h00
                       && tf.lba_mid_cur == 8'h00 && tf.lba_mid_prev == 8'h00)
                      || (tf.command == 8'hb0 && tf.feature == 8'hd5
                          && tf.lba_mid_cur == 8'h4f && tf.lba_high == 8'hc2));
  // Remembers whether the running command is a status request
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      stat_q <= 1'b0;
    else if (take)
      stat_q <= st_req;
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_sts_pulse: assert property (sts_valid |=> !sts_valid)
    else $error("status pulse longer than one cycle");
  a_take_busy: assert property (take |=> !cmd_ready)
    else $error("drive still ready after taking a command");
  a_cmd_hold: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(tf))
    else $error("command dropped or changed before acceptance");
  a_d2h_hold: assert property (d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data))
    else $error("outgoing byte dropped before acceptance");
  a_h2d_hold: assert property (h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data))
    else $error("incoming byte dropped before acceptance");
  a_log_cnt: assert property (take && (tf.command == 8'h2f || tf.command == 8'h3f)
      && tf.lba_low == 8'he1 && tf.count_cur != 8'h01 && tf.count_cur != 8'h08
      |=> sts_valid && sts_err) else $error("bad log transfer count not aborted");
  a_smart_zero: assert property (take && tf.command == 8'hb0 && tf.lba_low == 8'he1
      && tf.count_cur == 8'h00 |=> sts_valid && sts_err)
    else $error("zero count transfer not aborted");
  a_first_byte: assert property (st_req |-> ##[1:3] d2h_valid)
    else $error("status page did not start");
  a_status_ok: assert property (sts_valid && stat_q |-> !sts_err)
    else $error("status request refused");
endmodule : sctx_chk

// *** tb/sctx_log_transfer_status_decode_tb.sv ***
// Bench joining host and drive ends, driving registers and user side
`timescale 1ns/1ps
module sctx_log_transfer_status_decode_tb;
  import sctx_pkg::*;
  logic        clk_sys_i     = 1'b0;
  logic        reset_i       = 1'b1;
  logic [4:0]  avs_address   = 5'h00;
  logic        avs_read      = 1'b0;
  logic        avs_write     = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq_o;
  logic        bg_active_i   = 1'b0;
  logic        bg_done_i     = 1'b0;
  logic [15:0] bg_status_i   = 16'h0;
  logic [7:0]  usr_rd_data_i;
  logic [7:0]  rd_src        = 8'h00;
  logic        sct_cmd_o;
  logic        usr_wr_valid_o;
  logic        usr_rd_take_o;
  logic [15:0] sct_action_o;
  logic [15:0] sct_function_o;
  logic [7:0]  usr_wr_data_o;
  logic [31:0] rd;
  logic [7:0]  pg [512];
  int          fail_count      = 0;
  int          samples_checked = 0;
  int          cycles          = 0;
  int          wr_seen         = 0;
  int          keys            = 0;
  // Next read byte already counts a take that is still pending
  assign usr_rd_data_i = rd_src + {7'h0, usr_rd_take_o};
  sctx_if link_if ();
  sctx_host sctx_host_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .link(link_if),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq_o(irq_o));
  sctx_dev sctx_dev_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .link(link_if),
    .bg_active_i(bg_active_i), .bg_done_i(bg_done_i), .bg_status_i(bg_status_i),
    .sct_cmd_o(sct_cmd_o), .sct_action_o(sct_action_o), .sct_function_o(sct_function_o),
    .usr_wr_valid_o(usr_wr_valid_o), .usr_wr_data_o(usr_wr_data_o),
    .usr_rd_take_o(usr_rd_take_o), .usr_rd_data_i(usr_rd_data_i));
  sctx_chk sctx_chk_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .cmd_valid(link_if.cmd_valid), .cmd_ready(link_if.cmd_ready), .tf(link_if.tf),
    .h2d_valid(link_if.h2d_valid), .h2d_ready(link_if.h2d_ready),
    .h2d_data(link_if.h2d_data), .d2h_valid(link_if.d2h_valid),
    .d2h_ready(link_if.d2h_ready), .d2h_data(link_if.d2h_data),
    .sts_valid(link_if.sts_valid), .sts_err(link_if.sts_err));
  always #12.5 clk_sys_i = ~clk_sys_i;
  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  task conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude
  // Hang guard, user read source and user write sink
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (usr_rd_take_o === 1'b1)
      rd_src <= rd_src + 8'h01;
    if (sct_cmd_o === 1'b1)
      keys++;
    if (usr_wr_valid_o === 1'b1)
    begin
      check(usr_wr_data_o, wr_seen[7:0], "user write byte");
      wr_seen++;
    end
    if (cycles == 90000)
    begin
      fail_count++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One Avalon access, held until waitrequest is sampled low
  task av(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= wd;
    do @(posedge clk_sys_i); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk_sys_i);
  endtask : av
  task issue(input logic [1:0] op, input logic lg, input logic [7:0] cnt);
    av(1'b1, 5'h00, {20'h0, cnt, lg, op, 1'b1});
  endtask : issue
  task done(input logic err);
    rd = 32'h0;
    while (rd[1:0] === 2'b00)
      av(1'b0, 5'h0c, 32'h0);
    check(rd[1], err, "error flag");
    check(irq_o, 1'b1, "irq raised");
    av(1'b1, 5'h14, 32'h3);
    check(irq_o, 1'b0, "irq cleared");
  endtask : done
  task page(input logic lg, input logic [7:0] drv, input logic [15:0] ext, act, fn);
    issue(2'h0, lg, 8'h01);
    for (int i = 0; i < 512; i++)
    begin
      av(1'b0, 5'h08, 32'h0);
      pg[i] = rd[7:0];
    end
    done(1'b0);
    check({pg[1], pg[0], pg[5], pg[4]}, 32'h00030001, "versions");
    check(pg[10], drv, "drive status");
    check({pg[15], pg[14]}, ext, "extended status");
    check({pg[17], pg[16], pg[19], pg[18]}, {act, fn}, "codes");
    check({pg[200], pg[202], pg[511]}, 24'h808000, "tail");
  endtask : page
  task key(input logic lg, input logic [15:0] act, fn);
    issue(2'h1, lg, 8'h01);
    for (int i = 0; i < 512; i++)
      av(1'b1, 5'h08, {fn, act} >> (8 * i));
    done(1'b0);
    check({sct_action_o, sct_function_o}, {act, fn}, "key codes");
  endtask : key
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset();
    logic [4:0] adr [5] = '{5'h04, 5'h0c, 5'h10, 5'h14, 5'h1c};
    av(1'b1, 5'h04, 32'h3);
    av(1'b1, 5'h1c, 32'hff);
    foreach (adr[i])
    begin
      av(1'b0, adr[i], 32'h0);
      check(rd, 32'h0, "reset or unmapped value");
    end
    av(1'b1, 5'h10, 32'h3);
    $display("test reset done");
  endtask : t_reset
  task t_no_key();
    issue(2'h2, 1'b0, 8'h01);
    done(1'b1);
    av(1'b0, 5'h04, 32'h0);
    check(rd[1], 1'b1, "last error");
    page(1'b0, 8'h00, 16'h000b, 16'h0, 16'h0);
    $display("test no key done");
  endtask : t_no_key
  task t_bg();
    key(1'b1, 16'h0002, 16'h0001);
    bg_active_i <= 1'b1;
    page(1'b1, 8'h05, 16'hffff, 16'h0002, 16'h0001);
    check(keys, 1, "key count");
    bg_active_i <= 1'b0;
    bg_status_i <= 16'h0007;
    bg_done_i   <= 1'b1;
    @(posedge clk_sys_i);
    bg_done_i   <= 1'b0;
    page(1'b0, 8'h00, 16'h0007, 16'h0002, 16'h0001);
    $display("test background done");
  endtask : t_bg
  task t_xfer();
    key(1'b0, 16'h0005, 16'h0002);
    page(1'b1, 8'h00, 16'h0000, 16'h0005, 16'h0002);
    wr_seen = 0;
    issue(2'h3, 1'b1, 8'h01);
    for (int i = 0; i < 512; i++)
      av(1'b1, 5'h08, i);
    done(1'b0);
    check(wr_seen, 512, "write byte count");
    key(1'b0, 16'h0002, 16'h0001);
    wr_seen = 0;
    issue(2'h3, 1'b0, 8'h02);
    for (int i = 0; i < 1024; i++)
      av(1'b1, 5'h08, i);
    done(1'b0);
    check(wr_seen, 1024, "two sector write count");
    key(1'b1, 16'h0005, 16'h0003);
    issue(2'h2, 1'b0, 8'h01);
    for (int i = 0; i < 512; i++)
    begin
      av(1'b0, 5'h08, 32'h0);
      check(rd[7:0], i[7:0], "read byte");
    end
    done(1'b0);
    issue(2'h2, 1'b1, 8'h01);
    done(1'b1);
    $display("test transfer done");
  endtask : t_xfer
  task t_bad();
    av(1'b1, 5'h10, 32'h0);
    issue(2'h2, 1'b1, 8'h02);
    repeat (8) @(posedge clk_sys_i);
    check(irq_o, 1'b0, "irq masked");
    av(1'b1, 5'h10, 32'h3);
    done(1'b1);
    issue(2'h2, 1'b0, 8'h00);
    done(1'b1);
    $display("test bad encodings done");
  endtask : t_bad
  initial
  begin
    repeat (12) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(posedge clk_sys_i);
    t_reset();
    t_no_key();
    t_bg();
    t_xfer();
    t_bad();
    conclude();
  end
endmodule : sctx_log_transfer_status_decode_tb
